//--- hdl/aff_pkg.sv
// Constants and carrier types for the antenna fault flag logic
package aff_pkg;

   // ------------------------------------------------------------
   // Timing and sizing
   // ------------------------------------------------------------
   localparam int unsigned CLOCK_MHZ        = 100;
   localparam int unsigned CARRIER_KHZ      = 125;
   // Clock cycles in one carrier period, derived from the rates
   localparam int unsigned CARRIER_CYCLES   =
      (CLOCK_MHZ * 1000) / CARRIER_KHZ;
   localparam int unsigned CNT_W            = 16;
   localparam int unsigned SYNC_STAGES      = 3;
   // Diagnosis threshold in millivolts; analog, kept for reference
   localparam int          THRESHOLD_MV     = -1150;

   // ------------------------------------------------------------
   // Configuration page read command
   // ------------------------------------------------------------
   localparam logic [1:0]  PAGE_FAULT_A     = 2'h2;
   localparam logic [1:0]  PAGE_FAULT_B     = 2'h3;
   localparam int unsigned FLAG_BIT         = 0;
   localparam logic [3:0]  PAGE_DATA_RESET  = 4'h0;

   // Page read request from the command decoder
   typedef struct packed {
      logic       valid;
      logic [1:0] page;
   } aff_page_req_t;

   // Page read answer
   typedef struct packed {
      logic       valid;
      logic [3:0] data;
   } aff_page_rsp_t;

endpackage

//--- hdl/aff_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module aff_sync
   import aff_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Asynchronous input and filtered level
   input  wire logic async_in,
   output var  logic level
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [SYNC_STAGES-1:0] stage;
      logic                   level;
   } aff_sync_state_t;

   aff_sync_state_t state;
   aff_sync_state_t next_state;

   // Shift chain; level moves only when stages two and three agree
   always_comb begin
      next_state       = state;
      next_state.stage = {state.stage[SYNC_STAGES-2:0], async_in};
      if (state.stage[1] == state.stage[2]) begin
         next_state.level = state.stage[2];
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level = state.level;

endmodule
`default_nettype wire

//--- hdl/aff_flag.sv
// Antenna fault flag detector with configuration page read port
`timescale 1ns/100ps
`default_nettype none
module aff_flag
   import aff_pkg::*;
#(
   parameter int unsigned PERIOD = CARRIER_CYCLES
)(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // Analog front end: comparator, high while below threshold
   input  wire logic          below_threshold,
   // Page read command and answer
   input  wire aff_page_req_t page_req,
   output var  aff_page_rsp_t page_rsp,
   // Fault flag level and driver clock
   output var  logic          antenna_fault_flag,
   output var  logic          driver_clk
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             seen;
      logic             flag;
      logic             drv;
      aff_page_rsp_t    rsp;
   } aff_state_t;

   aff_state_t state;
   aff_state_t next_state;
   logic       crossing;

   // Last count of a carrier period
   function automatic logic [CNT_W-1:0] last_count(input int unsigned p);
      return CNT_W'(p - 1);
   endfunction

   // Pages that carry the fault flag
   function automatic logic is_flag_page(input logic [1:0] page);
      return (page == PAGE_FAULT_A) || (page == PAGE_FAULT_B);
   endfunction

   // Comparator passes the synchroniser before use
   aff_sync u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (below_threshold),
      .level    (crossing)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_state         = state;
      next_state.rsp     = '{valid: 1'b0, data: PAGE_DATA_RESET};
      // Carrier period counter drives the antenna driver clock
      if (state.cnt == last_count(PERIOD)) begin
         next_state.cnt  = '0;
      end else begin
         next_state.cnt  = state.cnt + CNT_W'(1);
      end
      next_state.drv     = (state.cnt < CNT_W'(PERIOD / 2));
      // Crossing in this cycle clears the flag at once
      if (crossing) begin
         next_state.seen = 1'b1;
         next_state.flag = 1'b0;
      end
      // End of period: judge the window and open a new one
      if (state.cnt == last_count(PERIOD)) begin
         next_state.seen = 1'b0;
         // No crossing in the whole window, also with the field gone
         if (!state.seen && !crossing) begin
            next_state.flag = 1'b1;
         end
      end
      // Page read: pages 2 and 3 carry the flag
      if (page_req.valid) begin
         next_state.rsp.valid = 1'b1;
         if (is_flag_page(page_req.page)) begin
            next_state.rsp.data[FLAG_BIT] = state.flag;
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs from flip-flops; nothing here switches drivers off
   assign page_rsp           = state.rsp;
   assign antenna_fault_flag = state.flag;
   assign driver_clk         = state.drv;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_flag_sets: assert property (
      @(posedge clock) disable iff (!rst_n)
      (state.cnt == last_count(PERIOD) && !state.seen && !crossing)
      |=> antenna_fault_flag)
      else $error("flag not set after quiet period");

   chk_flag_clears: assert property (
      @(posedge clock) disable iff (!rst_n)
      crossing |=> !antenna_fault_flag)
      else $error("flag not cleared on crossing");

   chk_no_false_set: assert property (
      @(posedge clock) disable iff (!rst_n)
      (!antenna_fault_flag && (state.seen || crossing))
      |=> !antenna_fault_flag)
      else $error("flag set despite crossing");

   chk_period_wrap: assert property (
      @(posedge clock) disable iff (!rst_n)
      (state.cnt == last_count(PERIOD)) |=> (state.cnt == '0))
      else $error("period counter wrap wrong");

   chk_window_open: assert property (
      @(posedge clock) disable iff (!rst_n)
      (state.cnt == last_count(PERIOD) && !crossing) |=> !state.seen)
      else $error("window not reopened");

   chk_page_flag: assert property (
      @(posedge clock) disable iff (!rst_n)
      (page_req.valid && is_flag_page(page_req.page))
      |=> (page_rsp.valid && page_rsp.data[FLAG_BIT] ==
           $past(antenna_fault_flag)))
      else $error("page read lost the flag");

   chk_page_other: assert property (
      @(posedge clock) disable iff (!rst_n)
      (page_req.valid && !is_flag_page(page_req.page))
      |=> (page_rsp.data == '0))
      else $error("other page shows flag");

   chk_flag_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      (!crossing && state.cnt != last_count(PERIOD))
      |=> $stable(antenna_fault_flag))
      else $error("flag moved without cause");

   // ------------------------------------------------------------
   // Checks on the answer pulse, driver clock, period counter, window marking and flag edges
   // ------------------------------------------------------------

   // Every request is answered in the next cycle
   chk_rsp_answer: assert property (
      @(posedge clock) disable iff (!rst_n)
      page_req.valid |=> page_rsp.valid)
      else $error("request not answered");

   // No request, no answer: the pulse stands one cycle only
   chk_rsp_idle: assert property (
      @(posedge clock) disable iff (!rst_n)
      !page_req.valid
      |=> (!page_rsp.valid && page_rsp.data == PAGE_DATA_RESET))
      else $error("answer without request");

   // Driver clock high in the first half of the period
   chk_drv_high: assert property (
      @(posedge clock) disable iff (!rst_n)
      (state.cnt < CNT_W'(PERIOD / 2)) |=> driver_clk)
      else $error("driver clock low in first half");

   // Driver clock low in the second half of the period
   chk_drv_low: assert property (
      @(posedge clock) disable iff (!rst_n)
      (state.cnt >= CNT_W'(PERIOD / 2)) |=> !driver_clk)
      else $error("driver clock high in second half");

   // Counter advances by one inside a period
   chk_count_step: assert property (
      @(posedge clock) disable iff (!rst_n)
      (state.cnt != last_count(PERIOD))
      |=> (state.cnt == $past(state.cnt) + CNT_W'(1)))
      else $error("period counter skipped");

   // Crossing inside a window marks it as seen
   chk_seen_marks: assert property (
      @(posedge clock) disable iff (!rst_n)
      (crossing && state.cnt != last_count(PERIOD)) |=> state.seen)
      else $error("crossing not recorded");

   // A set flag leaves the driver clock running
   chk_drivers_run: assert property (
      @(posedge clock) disable iff (!rst_n)
      (antenna_fault_flag && state.cnt == '0) |=> driver_clk)
      else $error("driver clock stopped on fault");

   // Flag rises only at the end of a quiet window
   chk_set_at_end: assert property (
      @(posedge clock) disable iff (!rst_n)
      $rose(antenna_fault_flag)
      |-> ($past(state.cnt) == last_count(PERIOD) && !$past(state.seen)))
      else $error("flag set outside window end");

   // Flag never rises right after a crossing
   chk_set_quiet: assert property (
      @(posedge clock) disable iff (!rst_n)
      $rose(antenna_fault_flag) |-> !$past(crossing))
      else $error("flag set despite crossing");

endmodule
`default_nettype wire

//--- tb/aff_host.sv
// Host model: page reads and polling of the fault flag
`timescale 1ns/100ps
`default_nettype none
module aff_host
   import aff_pkg::*;
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // Page read port
   output var  aff_page_req_t page_req,
   input  wire aff_page_rsp_t page_rsp
);
   initial page_req = '0;
   // One read; answer stands in the cycle after the take
   // No request is raised while reset holds the block
   task automatic read(input logic [1:0] page, output aff_page_rsp_t rsp);
      @(posedge clock);
      #1 page_req = '{valid: rst_n, page: page};
      @(posedge clock);
      #1 page_req.valid = 1'b0;
      rsp = page_rsp;
   endtask
   // Poll the flag; host would switch drivers off on a set flag
   task automatic poll(output logic fault);
      aff_page_rsp_t r;
      read(PAGE_FAULT_A, r);
      fault = r.data[FLAG_BIT];
   endtask
endmodule
`default_nettype wire

//--- tb/tb_antenna_fault_flag_logic.sv
// Bench for the antenna fault flag logic
`timescale 1ns/100ps
`default_nettype none
module tb_antenna_fault_flag_logic;
   import aff_pkg::*;
   localparam int unsigned P = 16;
   logic          clock           = 1'b0;
   logic          rst_n           = 1'b0;
   logic          below_threshold = 1'b0;
   logic          healthy         = 1'b1;
   logic [2:0]    ph              = 3'h0;
   logic          flag;
   logic          drv_clk;
   aff_page_req_t req;
   aff_page_rsp_t rsp;
   int            errors          = 0;
   int            tests_run       = 0;
   always #5 clock = ~clock;
   aff_flag #(.PERIOD(P)) u_dut (.clock(clock), .rst_n(rst_n),
      .below_threshold(below_threshold), .page_req(req),
      .page_rsp(rsp), .antenna_fault_flag(flag), .driver_clk(drv_clk));
   aff_host u_host (.clock(clock), .rst_n(rst_n), .page_req(req),
      .page_rsp(rsp));
   // Working antenna: crossing for 4 of every 8 cycles
   always @(posedge clock) begin
      #1 below_threshold = healthy & ph[2];
      ph = ph + 3'h1;
   end
   task automatic check(input string what, input logic [4:0] exp,
                        input logic [4:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Bounded wait for the flag to reach a level
   task automatic wait_flag(input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge clock);
         #1;
         if (flag === v) break;
      end
      check("flag level", {4'h0, v}, {4'h0, flag});
      if (n == lim) end_of_test();
   endtask
   // Working antenna keeps the flag low over many periods
   task automatic t_healthy();
      aff_page_rsp_t r;
      logic seen;
      seen = 1'b0;
      repeat (4 * P) begin
         @(posedge clock);
         #1 seen = seen | (flag !== 1'b0);
      end
      check("flag while healthy", 5'h00, {4'h0, seen});
      u_host.read(PAGE_FAULT_B, r);
      check("page 3 healthy", 5'h10, r);
   endtask
   // No crossing: flag sets, reads back on pages 2 and 3 only
   task automatic t_fault();
      aff_page_rsp_t r;
      logic f;
      int tog;
      healthy = 1'b0;
      wait_flag(1'b1, 2 * P + 8);
      for (int p = 0; p < 4; p++) begin
         u_host.read(p[1:0], r);
         check("page data", {1'b1, 3'h0, p >= 2}, r);
      end
      u_host.poll(f);
      check("polled flag", 5'h01, {4'h0, f});
      tog = 0;
      repeat (P) begin
         f = drv_clk;
         @(posedge clock);
         #1 tog += (drv_clk !== f);
      end
      check("driver toggles", 5'h02, tog[4:0]);
   endtask
   // Crossing returns: flag clears without any host action
   task automatic t_clear();
      healthy = 1'b1;
      wait_flag(1'b0, 16);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1 rst_n = 1'b1;
      t_healthy();
      t_fault();
      t_clear();
      end_of_test();
   end
endmodule
`default_nettype wire
